// ===== core/awd_pkg.sv
/*
  Shared constants and types for the converter control and window detector.
  Assumes one system clock domain and a byte-wide register port driven by
  the processor side; nothing here holds state.
*/
package awd_pkg;

  // ---------------------------------------------------------------------
  // Register addresses on the byte-wide register port
  // ---------------------------------------------------------------------
  localparam logic [7:0] AWD_CTRL_ADDR   = 8'hE8; // adc_control_status.
  localparam logic [7:0] AWD_GTH_ADDR    = 8'hC4; // greater_limit_high.
  localparam logic [7:0] AWD_GTL_ADDR    = 8'hC3; // greater_limit_low.
  localparam logic [7:0] AWD_LTH_ADDR    = 8'hC6; // less_limit_high.
  localparam logic [7:0] AWD_LTL_ADDR    = 8'hC5; // less_limit_low.
  localparam logic [7:0] AWD_RESH_ADDR   = 8'hBE; // result_word_high.
  localparam logic [7:0] AWD_RESL_ADDR   = 8'hBD; // result_word_low.

  // ---------------------------------------------------------------------
  // Bit positions inside adc_control_status
  // ---------------------------------------------------------------------
  localparam int AWD_BIT_EN   = 7; // converter_enable.
  localparam int AWD_BIT_TM   = 6; // tracking_mode_select.
  localparam int AWD_BIT_DONE = 5; // conversion_done_flag.
  localparam int AWD_BIT_BUSY = 4; // conversion_busy_start.
  localparam int AWD_BIT_WIN  = 3; // window_compare_flag.
  localparam int AWD_SRC_MSB  = 2; // start_source_select, upper bit.

  // ---------------------------------------------------------------------
  // Values after reset and encodings
  // ---------------------------------------------------------------------
  localparam logic [7:0]  AWD_CTRL_RST  = 8'h00;
  localparam logic [15:0] AWD_LIMIT_RST = 16'h0000;
  localparam logic [15:0] AWD_RES_RST   = 16'h0000;
  localparam logic [7:0]  AWD_RDATA_RST = 8'h00;
  localparam logic [2:0]  AWD_SRC_SW    = 3'h0; // Start by writing the busy bit.

  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  typedef enum logic {AWD_IDLE, AWD_CONV} awd_state_e;

  // One access on the register port.
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } awd_sfr_s;

  // End of conversion report from the converter core.
  typedef struct packed {
    logic       done;
    logic [9:0] data;
  } awd_conv_s;

  // The whole state of the control block.
  typedef struct packed {
    awd_state_e  state;
    logic        en;
    logic        tm;
    logic        done;
    logic        win;
    logic [2:0]  src;
    logic [15:0] gt;
    logic [15:0] lt;
    logic [15:0] res;
    logic [7:0]  rdata;
    logic        start;
  } awd_regs_s;

  // Right-justified result word; differential results are sign-extended.
  function automatic logic [15:0] awd_extend(input logic [9:0] d, input logic diff);
    awd_extend = {{6{diff & d[9]}}, d};
  endfunction : awd_extend

endpackage : awd_pkg

// ===== core/awd_win_cmp.sv
/*
  Window comparator: decides whether a 10-bit result meets the window set by
  a greater-than and a less-than limit. Purely combinational; the caller
  samples the answer on the cycle that a conversion ends.
*/
`timescale 1ns/1ps
module awd_win_cmp (
  // Operands
  input  wire logic [9:0] result,
  input  wire logic [9:0] gt_limit,
  input  wire logic [9:0] lt_limit,
  // Mode: high for two's-complement differential data
  input  wire logic       diff_mode,
  // Answer
  output logic            hit
);
  import awd_pkg::*;

  // Flipping the sign bit maps two's-complement order onto unsigned order,
  // so one set of unsigned comparators serves both modes.
  function automatic logic [9:0] awd_key(input logic [9:0] v, input logic diff);
    awd_key = {v[9] ^ diff, v[8:0]};
  endfunction : awd_key

  logic [9:0] r_k;   // Ordered result.
  logic [9:0] g_k;   // Ordered greater-than limit.
  logic [9:0] l_k;   // Ordered less-than limit.

  // Compare in the ordering that the mode asks for.
  always_comb begin
    r_k = awd_key(result, diff_mode);   // [RQ6] [RQ7]
    g_k = awd_key(gt_limit, diff_mode); // [RQ6] [RQ7]
    l_k = awd_key(lt_limit, diff_mode); // [RQ6] [RQ7]
    if (l_k > g_k) begin
      // Inside window: strictly between the two limits.
      hit = (r_k > g_k) && (r_k < l_k); // [RQ4] [RQ5]
    end else begin
      // Outside window: below less-than or above greater-than.
      hit = (r_k < l_k) || (r_k > g_k); // [RQ4]
    end
  end

endmodule : awd_win_cmp

// ===== core/awd_ctrl.sv
/*
  Control, status and window-detector registers of a 10-bit converter.
  Assumes a same-clock converter core that takes a one-cycle start pulse and
  reports the end of a conversion with a one-cycle done strobe and the data.
  The register port is a synchronous byte port with separate strobes.
*/
// Notes on behaviour
// RQ1: Compare every new result against both limits.
// RQ2: Window flag readable by software for polling.
// RQ3: Limits from greater and less registers, byte-split.
// RQ4: Limit ordering alone picks inside or outside.
// RQ5: Less above greater: flag strictly between limits.
// RQ6: Single-ended: compare as 10-bit unsigned values.
// RQ7: Differential: compare as 10-bit signed values.
// RQ8: Busy write starts conversion; busy, then done flag.
`timescale 1ns/1ps
module awd_ctrl (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  // Register port
  input  awd_pkg::awd_sfr_s sfr,
  output logic [7:0]        sfr_rdata,
  // Converter core
  input  awd_pkg::awd_conv_s conv,
  input  wire logic         differential_mode,
  output logic              conv_start,
  output logic              converter_enable,
  output logic              tracking_mode_select,
  // Status levels
  output logic              conversion_done_flag,
  output logic              window_compare_flag
);
  import awd_pkg::*;

  // -----------------------------------------------------------------------
  // State
  // -----------------------------------------------------------------------
  awd_regs_s q_r;    // Registered state.
  awd_regs_s q_nxt;  // Next state.
  logic      hit;    // Comparator answer for the incoming result.
  logic      conv_end; // Conversion finishes this cycle.
  logic      sw_start; // Software start request accepted this cycle.

  // The comparator looks at the word being delivered, so the flag lands
  // together with the result register rather than one cycle behind it.
  awd_win_cmp u_cmp (
    .result    (conv.data),
    .gt_limit  (q_r.gt[9:0]),
    .lt_limit  (q_r.lt[9:0]),
    .diff_mode (differential_mode),
    .hit       (hit)
  );

  // -----------------------------------------------------------------------
  // Next-state logic
  // -----------------------------------------------------------------------
  // Register writes come first and hardware events last, so an event in the
  // cycle that software clears its flag still leaves the flag set.
  always_comb begin
    q_nxt       = q_r;
    q_nxt.start = 1'b0;
    conv_end    = (q_r.state == AWD_CONV) && conv.done;
    sw_start    = sfr.wr && (sfr.addr == AWD_CTRL_ADDR) && sfr.wdata[AWD_BIT_BUSY]
                  && (sfr.wdata[AWD_SRC_MSB:0] == AWD_SRC_SW) && sfr.wdata[AWD_BIT_EN]
                  && (q_r.state == AWD_IDLE);
    if (sfr.wr) begin
      case (sfr.addr)
        AWD_CTRL_ADDR: begin
          q_nxt.en   = sfr.wdata[AWD_BIT_EN];
          q_nxt.tm   = sfr.wdata[AWD_BIT_TM];
          q_nxt.done = sfr.wdata[AWD_BIT_DONE];
          q_nxt.win  = sfr.wdata[AWD_BIT_WIN];
          q_nxt.src  = sfr.wdata[AWD_SRC_MSB:0];
        end
        AWD_GTH_ADDR: q_nxt.gt[15:8] = sfr.wdata; // [RQ3]
        AWD_GTL_ADDR: q_nxt.gt[7:0]  = sfr.wdata; // [RQ3]
        AWD_LTH_ADDR: q_nxt.lt[15:8] = sfr.wdata; // [RQ3]
        AWD_LTL_ADDR: q_nxt.lt[7:0]  = sfr.wdata; // [RQ3]
        default: begin
          // Result registers and unmapped addresses ignore writes.
        end
      endcase
    end
    // Conversion sequencing.
    case (q_r.state)
      AWD_IDLE: begin
        if (sw_start) begin
          q_nxt.start = 1'b1;      // [RQ8]
          q_nxt.state = AWD_CONV;  // [RQ8]
        end
      end
      AWD_CONV: begin
        if (conv.done) begin
          q_nxt.state = AWD_IDLE;
          q_nxt.res   = awd_extend(conv.data, differential_mode);
          q_nxt.done  = 1'b1;      // [RQ8]
          if (hit) begin
            q_nxt.win = 1'b1;      // [RQ1]
          end
        end
      end
      default: q_nxt.state = AWD_IDLE;
    endcase
    // Read data is registered; busy reflects the live conversion state.
    case (sfr.addr)
      AWD_CTRL_ADDR: q_nxt.rdata = {q_r.en, q_r.tm, q_r.done, q_r.state == AWD_CONV,
                                    q_r.win, q_r.src}; // [RQ2]
      AWD_GTH_ADDR:  q_nxt.rdata = q_r.gt[15:8];
      AWD_GTL_ADDR:  q_nxt.rdata = q_r.gt[7:0];
      AWD_LTH_ADDR:  q_nxt.rdata = q_r.lt[15:8];
      AWD_LTL_ADDR:  q_nxt.rdata = q_r.lt[7:0];
      AWD_RESH_ADDR: q_nxt.rdata = q_r.res[15:8];
      AWD_RESL_ADDR: q_nxt.rdata = q_r.res[7:0];
      default:       q_nxt.rdata = AWD_RDATA_RST;
    endcase
    if (!sfr.rd) begin
      q_nxt.rdata = q_r.rdata; // Hold the last answer between reads.
    end
  end

  // -----------------------------------------------------------------------
  // State register
  // -----------------------------------------------------------------------
  // Every field takes a constant under reset.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      q_r.state <= AWD_IDLE;
      q_r.en    <= AWD_CTRL_RST[AWD_BIT_EN];
      q_r.tm    <= AWD_CTRL_RST[AWD_BIT_TM];
      q_r.done  <= AWD_CTRL_RST[AWD_BIT_DONE];
      q_r.win   <= AWD_CTRL_RST[AWD_BIT_WIN];
      q_r.src   <= AWD_CTRL_RST[AWD_SRC_MSB:0];
      q_r.gt    <= AWD_LIMIT_RST;
      q_r.lt    <= AWD_LIMIT_RST;
      q_r.res   <= AWD_RES_RST;
      q_r.rdata <= AWD_RDATA_RST;
      q_r.start <= 1'b0;
    end else begin
      q_r <= q_nxt;
    end
  end

  // -----------------------------------------------------------------------
  // Outputs, all straight from the state register
  // -----------------------------------------------------------------------
  assign sfr_rdata            = q_r.rdata;
  assign conv_start           = q_r.start;
  assign converter_enable     = q_r.en;
  assign tracking_mode_select = q_r.tm;
  assign conversion_done_flag = q_r.done;
  assign window_compare_flag  = q_r.win;

  // -----------------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence s_sw_start;
    sw_start;
  endsequence

  sequence s_conv_end;
    (q_r.state == AWD_CONV) && conv.done;
  endsequence

  a_start_pulse: assert property ( // [RQ8]
    s_sw_start |=> conv_start && (q_r.state == AWD_CONV) ##1 !conv_start)
    else $error("software start did not give one start pulse");

  a_start_cause: assert property ( // [RQ8]
    conv_start |-> $past(sw_start))
    else $error("start pulse without a software start");

  a_end_done: assert property ( // [RQ8]
    s_conv_end |=> conversion_done_flag && (q_r.state == AWD_IDLE))
    else $error("conversion end did not set done flag");

  a_win_set: assert property ( // [RQ1]
    s_conv_end and hit |=> window_compare_flag)
    else $error("window hit did not set the flag");

  a_win_cause: assert property ( // [RQ1]
    $rose(window_compare_flag) |-> ($past(conv_end) && $past(hit))
      || ($past(sfr.wr) && ($past(sfr.addr) == AWD_CTRL_ADDR)
          && $past(sfr.wdata[AWD_BIT_WIN])))
    else $error("window flag rose without cause");

  a_win_read: assert property ( // [RQ2]
    sfr.rd && sfr.addr == AWD_CTRL_ADDR |=> sfr_rdata[AWD_BIT_WIN] == $past(q_r.win))
    else $error("window flag not readable");

  a_limit_wr: assert property ( // [RQ3]
    sfr.wr && sfr.addr == AWD_LTL_ADDR |=> q_r.lt[7:0] == $past(sfr.wdata))
    else $error("less limit low byte not stored");

  a_inside_u: assert property ( // [RQ5] [RQ6]
    conv_end && !differential_mode && (q_r.lt[9:0] > q_r.gt[9:0])
      |-> hit == ((conv.data > q_r.gt[9:0]) && (conv.data < q_r.lt[9:0])))
    else $error("unsigned inside window wrong");

  a_outside_s: assert property ( // [RQ4] [RQ7]
    conv_end && differential_mode && !($signed(q_r.lt[9:0]) > $signed(q_r.gt[9:0]))
      |-> hit == (($signed(conv.data) < $signed(q_r.lt[9:0]))
                  || ($signed(conv.data) > $signed(q_r.gt[9:0]))))
    else $error("signed outside window wrong");

  a_inside_s: assert property ( // [RQ5] [RQ7]
    conv_end && differential_mode && ($signed(q_r.lt[9:0]) > $signed(q_r.gt[9:0]))
      |-> hit == (($signed(conv.data) > $signed(q_r.gt[9:0]))
                  && ($signed(conv.data) < $signed(q_r.lt[9:0]))))
    else $error("signed inside window wrong");

  a_outside_u: assert property ( // [RQ4] [RQ6]
    conv_end && !differential_mode && !(q_r.lt[9:0] > q_r.gt[9:0])
      |-> hit == ((conv.data < q_r.lt[9:0]) || (conv.data > q_r.gt[9:0])))
    else $error("unsigned outside window wrong");

  // A clearing write that meets the end of a conversion must not hide the
  // event, or polling software would miss a result.
  a_set_wins: assert property ( // [RQ1] [RQ8]
    s_conv_end and (hit && sfr.wr && (sfr.addr == AWD_CTRL_ADDR))
      |=> window_compare_flag && conversion_done_flag)
    else $error("software clear beat a hardware flag set");

  // A second start while busy is dropped, so the converter never sees a
  // start pulse in the middle of a conversion.
  a_busy_refuse: assert property ( // [RQ8]
    sfr.wr && (sfr.addr == AWD_CTRL_ADDR) && sfr.wdata[AWD_BIT_BUSY]
      && (q_r.state == AWD_CONV) |=> !conv_start)
    else $error("start accepted while busy");

  a_busy_read: assert property ( // [RQ8]
    sfr.rd && (sfr.addr == AWD_CTRL_ADDR)
      |=> sfr_rdata[AWD_BIT_BUSY] == ($past(q_r.state) == AWD_CONV))
    else $error("busy bit not readable");

endmodule : awd_ctrl

// ===== sim/adc_window_detector_control_bench.sv
/*
  Self-checking bench for the converter control and window detector registers.
  Assumes awd_pkg and awd_ctrl are compiled first; the bench plays both the
  processor register port and the converter core.
*/
`timescale 1ns/1ps
module adc_window_detector_control_bench;
  import awd_pkg::*;
  // ---------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic        diff;
    logic [15:0] gt;
    logic [15:0] lt;
    logic [9:0]  d;
    logic        w;
  } awd_row_s;
  logic       mclk              = 1'b0;  // 40 MHz clock.
  logic       sys_rst           = 1'b1;  // Held three cycles at start.
  awd_sfr_s   sfr               = '0;    // Register port request.
  awd_conv_s  conv              = '0;    // Converter end report.
  logic       differential_mode = 1'b0;  // Data format of the core.
  logic [7:0] sfr_rdata;
  logic       conv_start, converter_enable, tracking_mode_select;
  logic       conversion_done_flag, window_compare_flag;
  int         err_total         = 0;     // Mismatches seen.
  int         comparisons       = 0;     // Compares made.
  int         cycles            = 0;     // Cycles since time zero.
  logic [7:0] rv;                        // Last byte read.
  logic       seen;                      // Start pulse observed.
  awd_row_s   rows [18];                 // Ordinary window cases.

  awd_ctrl u_dut (.mclk(mclk), .sys_rst(sys_rst), .sfr(sfr), .sfr_rdata(sfr_rdata),
    .conv(conv), .differential_mode(differential_mode), .conv_start(conv_start),
    .converter_enable(converter_enable), .tracking_mode_select(tracking_mode_select),
    .conversion_done_flag(conversion_done_flag), .window_compare_flag(window_compare_flag));

  always #12.5 mclk = ~mclk;

  // ---------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------
  task automatic summarize;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // A write is taken at the edge that ends the strobe.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    sfr <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge mclk);
    sfr.wr <= 1'b0;
  endtask : wr

  // Read data is registered, so it is sampled just after the taking edge.
  task automatic rdchk(input string n, input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    sfr <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge mclk);
    sfr.rd <= 1'b0;
    #1 rv = sfr_rdata;
    chk(n, {8'h00, rv}, {8'h00, e});
  endtask : rdchk

  // Writes the control byte and watches three cycles for the start pulse.
  task automatic start(input logic [7:0] d, output logic st);
    wr(AWD_CTRL_ADDR, d);
    st = 1'b0;
    repeat (3) begin
      #1 if (conv_start === 1'b1) st = 1'b1;
      @(posedge mclk);
    end
  endtask : start

  task automatic finish_conv(input logic [9:0] d);
    @(posedge mclk);
    conv <= '{done: 1'b1, data: d};
    @(posedge mclk);
    conv.done <= 1'b0;
  endtask : finish_conv

  // A hang is cut short and reported as a mismatch.
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      err_total++;
      summarize();
    end
  end

  // ---------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------
  initial begin
    rows = '{'{0, 16'h0040, 16'h0080, 10'h040, 0}, '{0, 16'h0040, 16'h0080, 10'h041, 1},
      '{0, 16'h0040, 16'h0080, 10'h07F, 1}, '{0, 16'h0040, 16'h0080, 10'h080, 0},
      '{0, 16'h0040, 16'h0080, 10'h3FF, 0}, '{0, 16'h0080, 16'h0040, 10'h03F, 1},
      '{0, 16'h0080, 16'h0040, 10'h040, 0}, '{0, 16'h0080, 16'h0040, 10'h060, 0},
      '{0, 16'h0080, 16'h0040, 10'h080, 0}, '{0, 16'h0080, 16'h0040, 10'h081, 1},
      '{1, 16'hFFFF, 16'h0040, 10'h3FF, 0}, '{1, 16'hFFFF, 16'h0040, 10'h03F, 1},
      '{1, 16'hFFFF, 16'h0040, 10'h040, 0}, '{1, 16'hFFFF, 16'h0040, 10'h200, 0},
      '{1, 16'h0040, 16'hFFFF, 10'h3FF, 0}, '{1, 16'h0040, 16'hFFFF, 10'h041, 1},
      '{1, 16'h0040, 16'hFFFF, 10'h020, 0}, '{1, 16'hFFFF, 16'h0040, 10'h000, 1}};
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    // Reset values and an unmapped address.
    chk("flags_port", {conversion_done_flag, window_compare_flag, conv_start}, 3'b000);
    rdchk("ctrl_rst", AWD_CTRL_ADDR, 8'h00);
    rdchk("gth_rst", AWD_GTH_ADDR, 8'h00);
    rdchk("ltl_rst", AWD_LTL_ADDR, 8'h00);
    rdchk("resh_rst", AWD_RESH_ADDR, 8'h00);
    rdchk("unmapped", 8'h00, 8'h00);
    // Limit bytes and control bits read back.
    wr(AWD_GTH_ADDR, 8'hA5);
    wr(AWD_LTL_ADDR, 8'h5A);
    wr(AWD_CTRL_ADDR, 8'hC0);
    rdchk("gth_rw", AWD_GTH_ADDR, 8'hA5);
    rdchk("ltl_rw", AWD_LTL_ADDR, 8'h5A);
    rdchk("ctrl_rw", AWD_CTRL_ADDR, 8'hC0);
    chk("en_tm_port", {converter_enable, tracking_mode_select}, 2'b11);
    $display("test reset_and_access done");
    foreach (rows[i]) begin
      wr(AWD_GTH_ADDR, rows[i].gt[15:8]);
      wr(AWD_GTL_ADDR, rows[i].gt[7:0]);
      wr(AWD_LTH_ADDR, rows[i].lt[15:8]);
      wr(AWD_LTL_ADDR, rows[i].lt[7:0]);
      differential_mode <= rows[i].diff;
      start(8'h90, seen);
      chk("conv_start", seen, 1'b1);
      rdchk("busy", AWD_CTRL_ADDR, 8'h90);
      finish_conv(rows[i].d);
      rdchk("ctrl_end", AWD_CTRL_ADDR, {4'b1010, rows[i].w, 3'b000});
      chk("win_port", window_compare_flag, rows[i].w);
      rdchk("res_hi", AWD_RESH_ADDR, {{6{rows[i].diff & rows[i].d[9]}}, rows[i].d[9:8]});
      rdchk("res_lo", AWD_RESL_ADDR, rows[i].d[7:0]);
    end
    $display("test window_table done");
    // A start write that meets the end of a conversion: the start is refused
    // and the hardware sets of both flags win over the clearing write.
    start(8'h90, seen);
    chk("start_race", seen, 1'b1);
    fork
      wr(AWD_CTRL_ADDR, 8'h90);
      finish_conv(10'h000);
    join
    #1 chk("race_nostart", conv_start, 1'b0);
    rdchk("set_wins", AWD_CTRL_ADDR, 8'hA8);
    chk("set_wins_port", {conversion_done_flag, window_compare_flag}, 2'b11);
    $display("test set_wins done");
    // Software clears both flags by writing zero to them.
    wr(AWD_CTRL_ADDR, 8'h80);
    rdchk("clear", AWD_CTRL_ADDR, 8'h80);
    chk("clear_port", {conversion_done_flag, window_compare_flag}, 2'b00);
    // Starts from another source or with the converter off are ignored.
    start(8'h91, seen);
    chk("start_src", seen, 1'b0);
    rdchk("idle_src", AWD_CTRL_ADDR, 8'h81);
    start(8'h10, seen);
    chk("start_off", seen, 1'b0);
    $display("test refused_start done");
    // Reset in the middle of a conversion returns everything to idle.
    start(8'h90, seen);
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    chk("rst_port", {converter_enable, conversion_done_flag, conv_start}, 3'b000);
    rdchk("rst_ctrl", AWD_CTRL_ADDR, 8'h00);
    $display("test mid_reset done");
    summarize();
  end
endmodule : adc_window_detector_control_bench
